// [include/efs_defs.svh]
// constants for the port frame statistics block
`ifndef EFS_DEFS_SVH
`define EFS_DEFS_SVH
`define EFS_CNT_W 32
`define EFS_LEN_W 14
`define EFS_COLL_W 5
`define EFS_EXCESS_COLL 5'h10
`define EFS_MULTI_MAX 5'h0f
`define EFS_BIN64 14'h0040
`define EFS_BIN127 14'h007f
`define EFS_BIN255 14'h00ff
`define EFS_BIN511 14'h01ff
`define EFS_BIN1023 14'h03ff
`define EFS_BIN1024 14'h0400
`define EFS_MAXLEN_RST 14'h05ee
`define EFS_NUM_BINS 6
`endif

// [include/efs_pkg.sv]
// types for the port frame statistics block
package efs_pkg;
	typedef logic [31:0] efs_cnt_t;
	typedef logic [13:0] efs_len_t;
	typedef enum {EFS_IDLE, EFS_UPDATE} efs_state_t;
	typedef struct packed {
		logic valid;
		logic isTx;
		efs_len_t len;
		logic [4:0] collCount;
		logic lateColl;
		logic carrierLost;
		logic underrun;
		logic deferred;
	} efs_evt_t;
endpackage : efs_pkg

// [include/efs_inc_if.sv]
// increment request bus between classifier and counter cells
`timescale 1ns/1ps
interface efs_inc_if;
	logic inc;
	logic [14:0] amount;
	modport src (output inc, output amount);
	modport dst (input inc, input amount);
endinterface : efs_inc_if

// [rtl/efs_counter.sv]
// one wrapping statistics counter cell
`timescale 1ns/1ps
`include "efs_defs.svh"
module efs_counter #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// increment request
	efs_inc_if.dst req,
	// count value
	output logic [W-1:0] count
);
	import efs_pkg::*;
	typedef struct packed {
		logic [W-1:0] cnt;
	} efs_cell_t;
	efs_cell_t state_reg;
	efs_cell_t state_next;

	// add the requested amount once per request
	always_comb begin
		state_next = state_reg;
		if (req.inc) begin
			state_next.cnt = W'(state_reg.cnt + W'(req.amount)); // wraps
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign count = state_reg.cnt;
endmodule : efs_counter

// [rtl/efs_port_stats.sv]
// per-port frame statistics classifier and counters
//
// How it works
// - collision count also steps on half-duplex flow-control receive start
// - single-collision: good transmit, exactly one non-late collision
// - multiple-collision: good transmit, 2 to 15 non-late collisions
// - excessive: abandoned after 16 non-late collisions, no carrier loss
// - late collision frames counted whatever the earlier collision count
// - late collision excludes single, multiple and excessive counts; errors ignored
// - deferred: no collisions, no carrier loss or underrun, medium busy
// - carrier sense errors counted on transmit only
// - transmit octets add good transmit frame lengths
// - net octets add all bytes including partial and retried ones
// - size bins skip late, excessive and carrier-error frames other than 64 byte ones
// - 64 byte bin, including carrier-truncated transmit frames
// - 65 to 127 byte bin
// - 128 to 255 byte bin
// - 256 to 511 byte bin
// - 512 to 1023 byte bin
// - 1024 bin: receive up to max length, transmit unbounded
// - frame errors and overruns never block size binning
`timescale 1ns/1ps
`include "efs_defs.svh"
module efs_port_stats #(
	parameter int CW = `EFS_CNT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire logic [13:0] rxMaxLen,
	input wire logic halfDuplex,
	input wire logic flowCtrlActive,
	// frame completion report
	input wire efs_pkg::efs_evt_t evt,
	// receive start and collision octet reports
	input wire logic rxStart,
	input wire logic partialValid,
	input wire logic [13:0] partialLen,
	// counter values
	output logic [CW-1:0] collisions,
	output logic [CW-1:0] singleColl,
	output logic [CW-1:0] multiColl,
	output logic [CW-1:0] excessColl,
	output logic [CW-1:0] lateColl,
	output logic [CW-1:0] deferred,
	output logic [CW-1:0] carrierErr,
	output logic [CW-1:0] txOctets,
	output logic [CW-1:0] netOctets,
	output logic [CW-1:0] bin64,
	output logic [CW-1:0] bin127,
	output logic [CW-1:0] bin255,
	output logic [CW-1:0] bin511,
	output logic [CW-1:0] bin1023,
	output logic [CW-1:0] bin1024
);
	import efs_pkg::*;

	// -------------------------------------------------------------
	// registered frame event
	// -------------------------------------------------------------
	typedef struct packed {
		efs_state_t st;
		efs_evt_t ev;
		logic rxFc;
		logic partV;
		efs_len_t partLen;
		logic [13:0] maxLen;
	} efs_top_t;
	efs_top_t state_reg;
	efs_top_t state_next;

	// capture each report for one classification cycle
	always_comb begin
		state_next = state_reg;
		state_next.ev = evt;
		state_next.rxFc = rxStart & halfDuplex & flowCtrlActive;
		state_next.partV = partialValid;
		state_next.partLen = partialLen;
		state_next.maxLen = rxMaxLen;
		case (state_reg.st)
			EFS_IDLE: begin
				if (evt.valid) begin
					state_next.st = EFS_UPDATE;
				end
			end
			EFS_UPDATE: begin
				if (!evt.valid) begin
					state_next.st = EFS_IDLE;
				end
			end
			default: begin
				state_next.st = EFS_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.st <= EFS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// -------------------------------------------------------------
	// classification
	// -------------------------------------------------------------
	logic ev;
	logic tx;
	logic clean;
	logic good;
	logic binOk;
	logic [4:0] nColl;
	logic [13:0] len;
	logic [`EFS_NUM_BINS-1:0] binHit;

	assign ev = state_reg.ev.valid;
	assign tx = state_reg.ev.isTx;
	assign nColl = state_reg.ev.collCount;
	assign len = state_reg.ev.len;
	// transmit with neither carrier loss nor underrun
	assign clean = ev & tx & ~state_reg.ev.carrierLost
		& ~state_reg.ev.underrun;
	assign good = clean & ~state_reg.ev.lateColl
		& (nColl < `EFS_EXCESS_COLL);
	// carrier error only matters on transmit; crc etc not inputs
	assign binOk = ev & ~(tx & state_reg.ev.lateColl)
		& ~(tx & nColl >= `EFS_EXCESS_COLL)
		& ~(tx & state_reg.ev.carrierLost & len != `EFS_BIN64);

	// size bin decode
	always_comb begin
		binHit = '0;
		binHit[0] = len == `EFS_BIN64;
		binHit[1] = len > `EFS_BIN64 && len <= `EFS_BIN127;
		binHit[2] = len > `EFS_BIN127 && len <= `EFS_BIN255;
		binHit[3] = len > `EFS_BIN255 && len <= `EFS_BIN511;
		binHit[4] = len > `EFS_BIN511 && len <= `EFS_BIN1023;
		binHit[5] = len >= `EFS_BIN1024
			&& (tx || len <= state_reg.maxLen);
	end

	// -------------------------------------------------------------
	// counter cells
	// -------------------------------------------------------------
	efs_inc_if cReq[15]();
	logic [CW-1:0] cVal [15];
	logic [14:0] netAdd;
	logic collTx;

	// net octets: frame bytes plus partial bytes before collisions
	always_comb begin
		netAdd = '0;
		if (ev) begin
			netAdd = {1'b0, len};
		end
		// two 14-bit lengths always fit in 15 bits
		if (state_reg.partV) begin
			netAdd = 15'(netAdd + {1'b0, state_reg.partLen});
		end
	end

	// a collided transmit and a flow-control receive start may coincide
	assign collTx = clean & (state_reg.ev.lateColl | nColl != 5'h00);
	assign cReq[0].inc = collTx | state_reg.rxFc;
	assign cReq[0].amount = {13'h0000, collTx & state_reg.rxFc,
		collTx ^ state_reg.rxFc};
	assign cReq[1].inc = clean & ~state_reg.ev.lateColl
		& nColl == 5'h01;
	assign cReq[1].amount = 15'h0001;
	assign cReq[2].inc = clean & ~state_reg.ev.lateColl & nColl >= 5'h02
		& nColl <= `EFS_MULTI_MAX;
	assign cReq[2].amount = 15'h0001;
	assign cReq[3].inc = clean & ~state_reg.ev.lateColl
		& nColl == `EFS_EXCESS_COLL;
	assign cReq[3].amount = 15'h0001;
	assign cReq[4].inc = ev & tx & state_reg.ev.lateColl;
	assign cReq[4].amount = 15'h0001;
	assign cReq[5].inc = clean & nColl == 5'h00 & ~state_reg.ev.lateColl
		& state_reg.ev.deferred;
	assign cReq[5].amount = 15'h0001;
	assign cReq[6].inc = ev & tx & state_reg.ev.carrierLost;
	assign cReq[6].amount = 15'h0001;
	assign cReq[7].inc = good;
	assign cReq[7].amount = {1'b0, len};
	assign cReq[8].inc = ev | state_reg.partV;
	assign cReq[8].amount = netAdd;

	// one bin request per size range
	genvar gi;
	generate
		for (gi = 0; gi < `EFS_NUM_BINS; gi++) begin : g_bin
			assign cReq[9+gi].inc = binOk & binHit[gi];
			assign cReq[9+gi].amount = 15'h0001;
		end
		for (gi = 0; gi < 15; gi++) begin : g_cnt
			efs_counter #(.W(CW)) u_cnt (
				.clk(clk),
				.rst(rst),
				.req(cReq[gi]),
				.count(cVal[gi])
			);
		end
	endgenerate

	// outputs straight from counter flip-flops
	assign collisions = cVal[0];
	assign singleColl = cVal[1];
	assign multiColl = cVal[2];
	assign excessColl = cVal[3];
	assign lateColl = cVal[4];
	assign deferred = cVal[5];
	assign carrierErr = cVal[6];
	assign txOctets = cVal[7];
	assign netOctets = cVal[8];
	assign bin64 = cVal[9];
	assign bin127 = cVal[10];
	assign bin255 = cVal[11];
	assign bin511 = cVal[12];
	assign bin1023 = cVal[13];
	assign bin1024 = cVal[14];

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	// collision, deferral and carrier counts two edges after the report; fc_coll_a and carrier_rx_a check requests one edge after
	single_step_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & ~evt.carrierLost & ~evt.underrun
		& ~evt.lateColl & evt.collCount == 5'h01)
		|=> ##1 singleColl == $past(singleColl) + 1)
		else $error("single collision count did not step");
	late_excl_a: assert property (@(posedge clk) disable iff (rst)
		cReq[4].inc |-> !(cReq[1].inc | cReq[2].inc | cReq[3].inc))
		else $error("late collision also counted elsewhere");
	multi_range_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & ~evt.carrierLost & ~evt.underrun
		& ~evt.lateColl & evt.collCount >= 5'h02 & evt.collCount <= 5'h0f)
		|=> ##1 multiColl == $past(multiColl) + 1)
		else $error("multiple collision count did not step");
	excess_step_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & ~evt.carrierLost & ~evt.underrun
		& ~evt.lateColl & evt.collCount == 5'h10)
		|=> ##1 excessColl == $past(excessColl) + 1)
		else $error("excessive count did not step");
	late_step_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & evt.lateColl)
		|=> ##1 lateColl == $past(lateColl) + 1)
		else $error("late collision count did not step");
	fc_coll_a: assert property (@(posedge clk) disable iff (rst)
		(rxStart & halfDuplex & flowCtrlActive) |=> cReq[0].inc)
		else $error("flow control receive start not counted");
	coll_both_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & ~evt.carrierLost & ~evt.underrun
		& evt.collCount != 5'h00 & rxStart & halfDuplex & flowCtrlActive)
		|=> ##1 collisions == $past(collisions) + 2)
		else $error("collision and receive start not both counted");
	defer_step_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & ~evt.carrierLost & ~evt.underrun
		& ~evt.lateColl & evt.collCount == 5'h00 & evt.deferred)
		|=> ##1 deferred == $past(deferred) + 1)
		else $error("deferred frame not counted");
	carrier_rx_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & ~evt.isTx) |=> !cReq[6].inc)
		else $error("receive frame counted as carrier error");
	carrier_step_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & evt.carrierLost)
		|=> ##1 carrierErr == $past(carrierErr) + 1)
		else $error("carrier error count did not step");

	// octet counts
	tx_octets_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & ~evt.carrierLost & ~evt.underrun
		& ~evt.lateColl & evt.collCount < 5'h10)
		|=> ##1 txOctets == $past(txOctets) + $past(evt.len, 2))
		else $error("transmit octets did not accumulate");
	net_add_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & partialValid) |=> ##1 netOctets
		== $past(netOctets) + $past(evt.len, 2) + $past(partialLen, 2))
		else $error("net octets missed frame or partial bytes");

	// size bins
	bin_one_a: assert property (@(posedge clk) disable iff (rst)
		$onehot0({cReq[9].inc, cReq[10].inc, cReq[11].inc,
		cReq[12].inc, cReq[13].inc, cReq[14].inc}))
		else $error("frame put in more than one bin");
	bin64_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.len == 14'h0040 & ~evt.lateColl
		& evt.collCount < 5'h10) |=> cReq[9].inc)
		else $error("64 byte frame not binned");
	bin_small_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & ~evt.isTx & evt.len > 14'h0040 & evt.len < 14'h0080)
		|=> cReq[10].inc)
		else $error("65 to 127 byte frame not binned");
	bin_mid_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & ~evt.isTx & evt.len > 14'h007f & evt.len < 14'h0100)
		|=> cReq[11].inc)
		else $error("128 to 255 byte frame not binned");
	bin_large_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & ~evt.isTx & evt.len > 14'h00ff & evt.len < 14'h0200)
		|=> cReq[12].inc)
		else $error("256 to 511 byte frame not binned");
	bin_big_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & ~evt.isTx & evt.len > 14'h01ff & evt.len < 14'h0400)
		|=> cReq[13].inc)
		else $error("512 to 1023 byte frame not binned");
	rx_max_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & ~evt.isTx & evt.len > rxMaxLen) |=> !cReq[14].inc)
		else $error("oversize receive frame binned");
	tx_big_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & ~evt.carrierLost & ~evt.lateColl
		& evt.collCount < 5'h10 & evt.len >= 14'h0400)
		|=> ##1 bin1024 == $past(bin1024) + 1)
		else $error("long transmit frame not binned");
	carrier_bin_a: assert property (@(posedge clk) disable iff (rst)
		(evt.valid & evt.isTx & evt.carrierLost & evt.len != 14'h0040)
		|=> !(cReq[9].inc | cReq[10].inc | cReq[11].inc | cReq[12].inc
		| cReq[13].inc | cReq[14].inc))
		else $error("carrier error frame binned");
endmodule : efs_port_stats

// [test/efs_mac_model.sv]
// MAC side model that issues frame reports to the statistics block
`timescale 1ns/1ps
module efs_mac_model (
	// clock
	input wire logic clk,
	// next report from the bench
	input wire efs_pkg::efs_evt_t evtIn,
	input wire logic rxStartIn,
	input wire logic partValIn,
	input wire logic [13:0] partLenIn,
	// reports toward the block
	output efs_pkg::efs_evt_t evt,
	output logic rxStart,
	output logic partialValid,
	output logic [13:0] partialLen
);
	import efs_pkg::*;
	// idle fields flip every cycle so stale values never look valid
	always_ff @(posedge clk) begin
		evt <= evtIn.valid ? evtIn : {1'b0, ~evt[23:0]};
		rxStart <= rxStartIn;
		partialValid <= partValIn;
		partialLen <= partValIn ? partLenIn : ~partialLen;
	end
endmodule : efs_mac_model

// [test/ethernet_port_frame_statistics_tb.sv]
// self-checking bench for the port frame statistics block
`timescale 1ns/1ps
module ethernet_port_frame_statistics_tb;
	import efs_pkg::*;
	logic clk = 0, rst = 1, hd = 0, fc = 0, rs = 0, pv = 0, mRs, mPv;
	logic [13:0] rxMaxLen = 14'h05ee, pl = '0, mPl;
	logic [15:0] seed = 16'h549a;
	efs_evt_t ev = '0, mEv, e;
	logic [31:0] got [15];
	logic [31:0] ex [15] = '{default: '0};
	int err_total = 0, checked = 0;
	int lens [13] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023,
		1024, 1518, 1519};
	string nm [15] = '{"collisions", "singleColl", "multiColl",
		"excessColl", "lateColl", "deferred", "carrierErr", "txOctets",
		"netOctets", "bin64", "bin127", "bin255", "bin511", "bin1023",
		"bin1024"};
	// clock
	always #2.5 clk = ~clk;
	efs_mac_model efs_mac_model_inst (.clk(clk), .evtIn(ev),
		.rxStartIn(rs), .partValIn(pv), .partLenIn(pl), .evt(mEv),
		.rxStart(mRs), .partialValid(mPv), .partialLen(mPl));
	efs_port_stats efs_port_stats_inst (.clk(clk), .rst(rst),
		.rxMaxLen(rxMaxLen), .halfDuplex(hd), .flowCtrlActive(fc),
		.evt(mEv), .rxStart(mRs), .partialValid(mPv), .partialLen(mPl),
		.collisions(got[0]), .singleColl(got[1]), .multiColl(got[2]),
		.excessColl(got[3]), .lateColl(got[4]), .deferred(got[5]),
		.carrierErr(got[6]), .txOctets(got[7]), .netOctets(got[8]),
		.bin64(got[9]), .bin127(got[10]), .bin255(got[11]),
		.bin511(got[12]), .bin1023(got[13]), .bin1024(got[14]));
	// ----------------------------------------------------------------
	// expectation helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction : rnd
	function automatic efs_evt_t mk(logic tx, logic clean, logic [13:0] l);
		efs_evt_t r;
		r = efs_evt_t'(25'({rnd(), rnd()}));
		r.valid = 1'b1;
		r.isTx = tx;
		r.len = l;
		r.collCount = 5'(r.collCount % 17);
		if (r.lateColl && r.collCount == 16) r.collCount = 5'h0f;
		if (clean || !tx) r[8:0] = '0;
		return r;
	endfunction : mk
	// index of the size bin a frame lands in, zero for none
	function automatic int bin_of(efs_evt_t f);
		if (f.isTx && (f.lateColl || f.collCount == 16)) return 0;
		if (f.isTx && f.carrierLost && f.len != 64) return 0;
		if (f.len < 64) return 0;
		if (f.len == 64) return 9;
		if (f.len < 128) return 10;
		if (f.len < 256) return 11;
		if (f.len < 512) return 12;
		if (f.len < 1024) return 13;
		if (!f.isTx && f.len > rxMaxLen) return 0;
		return 14;
	endfunction : bin_of
	task automatic check(string n, logic [31:0] seen, logic [31:0] want);
		checked++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", n, want, seen);
		end
	endtask : check
	// one report cycle, with the counts it should cause
	task automatic drive(efs_evt_t f, logic r, logic p, logic [13:0] l);
		logic ok;
		int b;
		@(posedge clk);
		ev <= f;
		rs <= r;
		pv <= p;
		pl <= l;
		if (r && hd && fc) ex[0]++;
		if (p) ex[8] += 32'(l);
		if (f.valid) begin
			ok = !f.carrierLost && !f.underrun;
			ex[8] += 32'(f.len);
			if (f.isTx) begin
				if (ok && (f.collCount != 0 || f.lateColl)) ex[0]++;
				if (f.lateColl) ex[4]++;
				else if (ok && f.collCount == 1) ex[1]++;
				else if (ok && f.collCount inside {[2:15]}) ex[2]++;
				else if (ok && f.collCount == 16) ex[3]++;
				else if (ok && f.collCount == 0 && f.deferred) ex[5]++;
				if (f.carrierLost) ex[6]++;
				if (ok && !f.lateColl && f.collCount != 16)
					ex[7] += 32'(f.len);
			end
			b = bin_of(f);
			if (b != 0) ex[b]++;
		end
	endtask : drive
	task automatic settle(string t);
		drive('0, 1'b0, 1'b0, '0);
		repeat (4) @(posedge clk);
		#1;
		for (int i = 0; i < 8; i++)
			check(nm[i], got[i], ex[i]);
		check(nm[8], got[8], ex[8]);
		for (int i = 9; i < 15; i++)
			check(nm[i], got[i], ex[i]);
		$display("test done: %s", t);
	endtask : settle
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] r;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		foreach (lens[i]) for (int t = 0; t < 2; t++)
			drive(mk(t[0], 1'b1, 14'(lens[i])), 1'b0, 1'b0, '0);
		settle("bin boundaries");
		for (int c = 0; c < 17; c++) for (int lt = 0; lt < 2; lt++) begin
			e = mk(1'b1, 1'b1, 14'h0080);
			e.collCount = 5'(c);
			e.lateColl = lt[0] && c < 16;
			e.deferred = 1'b1;
			drive(e, 1'b0, 1'b1, 14'(c * 3));
		end
		foreach (lens[i]) begin
			e = mk(1'b1, 1'b1, 14'(lens[i]));
			e.carrierLost = i[0];
			e.underrun = ~i[0];
			drive(e, 1'b0, 1'b0, '0);
		end
		settle("collision and fault codes");
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			hd <= m[0];
			fc <= m[1];
			e = mk(1'b1, 1'b1, 14'h0041);
			e.collCount = 5'(m + 1);
			drive(e, 1'b1, 1'b1, 14'h0015);
			settle("receive start in each duplex mode");
		end
		for (int n = 0; n < 40; n++) begin
			r = rnd();
			@(posedge clk);
			hd <= r[0];
			fc <= r[1];
			rxMaxLen <= 14'h0400 + 14'(r[15:7]);
			repeat (8) begin
				r = rnd();
				e = r[0] ? mk(r[1], 1'b0, 14'(rnd() & 16'h07ff)) : '0;
				drive(e, r[2], r[3], 14'(r[15:6]));
			end
			settle("random burst");
		end
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (ex[i]) ex[i] = '0;
		// a report right after release must still be counted
		e = mk(1'b1, 1'b1, 14'h0040);
		e.collCount = 5'h01;
		drive(e, 1'b0, 1'b0, '0);
		settle("reset in mid run");
		give_verdict();
	end
endmodule : ethernet_port_frame_statistics_tb
